//--- dv/banked_data_memory_indirect_addressing_tb.sv
// self-checking bench for the banked data memory
`timescale 1ns/1ps
module banked_data_memory_indirect_addressing_tb;
	logic clk_in, nrst_in, wdt_sleep_rst_in, rd_in, wr_in, bit_op_in, bit_val_in;
	logic periph_hit_in, periph_ro_in, periph_we_out;
	logic [7:0] addr_in, wdata_in, rdata_out, periph_rdata_in, periph_addr_out, periph_wdata_out;
	logic [2:0] bit_sel_in;
	logic [3:0] nvc;
	int mismatches, samples_checked, cycles;
	bdm_core_model core_u (.clk_in, .addr_out(addr_in), .rd_out(rd_in), .wr_out(wr_in),
		.wdata_out(wdata_in), .bit_op_out(bit_op_in), .bit_sel_out(bit_sel_in),
		.bit_val_out(bit_val_in));
	bdm_top dut_u (.clk_in, .nrst_in, .wdt_sleep_rst_in, .addr_in, .rd_in, .wr_in, .wdata_in,
		.bit_op_in, .bit_sel_in, .bit_val_in, .rdata_out, .periph_rdata_in, .periph_hit_in,
		.periph_ro_in, .periph_we_out, .periph_addr_out, .periph_wdata_out,
		.nonvolatile_control_register_out(nvc));
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
	begin
		samples_checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		core_u.acc(a, 1'b1, d, 1'b0);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
	begin
		core_u.acc(a, 1'b0, 8'h00, 1'b0);
		chk($sformatf("rdata at %h", a), e, rdata_out);
	end
	endtask
	task wrap_up;
	begin
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask
	initial
	begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	// ceiling well above the roughly fifty cycles the sequence needs
	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			mismatches++;
			wrap_up();
		end
	end
	initial
	begin
		{nrst_in, wdt_sleep_rst_in, periph_hit_in, periph_ro_in} = 4'h0;
		periph_rdata_in = 8'h3c;
		repeat (8) @(posedge clk_in);
		#1 nrst_in = 1'b1;
		rd(8'h04, 8'h00);
		wr(8'h01, 8'ha5);
		rd(8'h01, 8'ha5);
		wr(8'h80, 8'h11);
		wr(8'hff, 8'h22);
		rd(8'h80, 8'h11);
		rd(8'hff, 8'h22);
		wr(8'h90, 8'h5a);
		rd(8'h90, 8'h5a);
		wr(8'h01, 8'hff);
		rd(8'h00, 8'h22);
		wr(8'h00, 8'h33);
		rd(8'hff, 8'h33);
		$display("test pointers and ram done");
		wr(8'h04, 8'h01);
		rd(8'hff, 8'h33);
		rd(8'h04, 8'h01);
		wr(8'h03, 8'h80);
		wr(8'h02, 8'h77);
		rd(8'h02, 8'h00);
		rd(8'h80, 8'h11);
		wr(8'h03, 8'h40);
		wr(8'h02, 8'h0a);
		rd(8'h02, 8'h0a);
		chk("control bits", 8'h0a, {4'h0, nvc});
		rd(8'h40, 8'h00);
		wdt_sleep_rst_in = 1'b1;
		wr(8'h04, 8'h00);
		rd(8'h04, 8'h01);
		nrst_in = 1'b0;
		@(posedge clk_in);
		#1 nrst_in = 1'b1;
		rd(8'h04, 8'h00);
		rd(8'h01, 8'h00);
		wdt_sleep_rst_in = 1'b0;
		wr(8'h04, 8'h00);
		wr(8'h03, 8'h80);
		rd(8'h02, 8'h11);
		$display("test banking done");
		wr(8'h01, 8'h02);
		wr(8'h00, 8'h55);
		rd(8'h00, 8'h00);
		rd(8'h02, 8'h11);
		core_u.acc(8'h80, 1'b1, 8'h85, 1'b1);
		rd(8'h80, 8'h31);
		{periph_hit_in, periph_ro_in} = 2'b11;
		core_u.acc(8'h10, 1'b1, 8'h5a, 1'b0);
		chk("peripheral write strobe", 8'h00, {7'h00, periph_we_out});
		rd(8'h10, 8'h3c);
		$display("test pointer loops, bit ops and peripherals done");
		wrap_up();
	end
endmodule

//--- dv/bdm_core_model.sv
// core-side access driver model for the banked data memory
`timescale 1ns/1ps
module bdm_core_model
(
	input  wire logic       clk_in,
	output logic      [7:0] addr_out,
	output logic            rd_out,
	output logic            wr_out,
	output logic      [7:0] wdata_out,
	output logic            bit_op_out,
	output logic      [2:0] bit_sel_out,
	output logic            bit_val_out
);
	initial
	begin
		{addr_out, rd_out, wr_out, wdata_out, bit_op_out, bit_sel_out, bit_val_out} = '0;
	end
	// one access per cycle; a write lands on the edge that ends the cycle
	task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d, input logic b);
	begin
		@(posedge clk_in);
		#1;
		addr_out = a;
		wr_out = w;
		rd_out = !w;
		wdata_out = d;
		bit_op_out = b;
		bit_sel_out = d[2:0];
		bit_val_out = d[7];
		#2;
	end
	endtask
endmodule

//--- dv/bdm_top_asserts.sv
// port-level assertions for the banked data memory
`timescale 1ns/1ps
module bdm_top_asserts
(
	input  wire logic       clk_in,
	input  wire logic       nrst_in,
	input  wire logic [7:0] addr_in,
	input  wire logic       rd_in,
	input  wire logic       wr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       bit_op_in,
	input  wire logic [7:0] rdata_out,
	input  wire logic       periph_hit_in,
	input  wire logic       periph_ro_in,
	input  wire logic       periph_we_out,
	input  wire logic [7:0] periph_addr_out,
	input  wire logic [7:0] periph_wdata_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	wire sfr = addr_in > 8'h04 && !addr_in[7];
	property p_direct; sfr |-> periph_addr_out == addr_in; endproperty
	a_direct: assert property (p_direct) else $error("direct address altered");
	property p_unused; rd_in && sfr && !periph_hit_in |-> rdata_out == 8'h00; endproperty
	a_unused: assert property (p_unused) else $error("unused address not zero");
	property p_ro; periph_ro_in |-> !periph_we_out; endproperty
	a_ro: assert property (p_ro) else $error("read-only register written");
	property p_we; wr_in && sfr && periph_hit_in && !periph_ro_in |-> periph_we_out; endproperty
	a_we: assert property (p_we) else $error("bank 0 register write lost");
	property p_ptr; (wr_in && addr_in == 8'h01 && !bit_op_in ##1 rd_in && addr_in == 8'h01)
		|-> rdata_out == $past(wdata_in); endproperty
	a_ptr: assert property (p_ptr) else $error("pointer readback wrong");
	property p_ram; (wr_in && addr_in[7] && !bit_op_in ##1 rd_in && $stable(addr_in))
		|-> rdata_out == $past(wdata_in); endproperty
	a_ram: assert property (p_ram) else $error("ram readback wrong");
	property p_bank; rd_in && addr_in == 8'h04 |-> rdata_out[7:1] == 7'h00; endproperty
	a_bank: assert property (p_bank) else $error("bank select upper bits set");
	property p_wdat; wr_in && !bit_op_in |-> periph_wdata_out == wdata_in; endproperty
	a_wdat: assert property (p_wdat) else $error("write data altered");
	property p_idle; !rd_in |-> rdata_out == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("read data driven while idle");
endmodule
bind bdm_top bdm_top_asserts chk_u (.clk_in, .nrst_in, .addr_in, .rd_in, .wr_in, .wdata_in,
	.bit_op_in, .rdata_out, .periph_hit_in, .periph_ro_in, .periph_we_out, .periph_addr_out,
	.periph_wdata_out);

//--- hdl/bdm_gp_ram.sv
// general purpose ram, 128 bytes of flip-flops
`timescale 1ns/1ps
module bdm_gp_ram
	import bdm_pkg::*;
(
	input  wire logic clk_in,
	bdm_ram_if.ram    port_in
);
	logic [7:0] mem_q [BDM_GP_DEPTH];

	// ram has no reset: contents are undefined at power-up, as in silicon
	always_ff @(posedge clk_in)
	begin
		if (port_in.we)
			mem_q[port_in.addr] <= port_in.wdata;
	end

	assign port_in.rdata = mem_q[port_in.addr];
endmodule

//--- hdl/bdm_pkg.sv
// package of constants for the banked data memory block
package bdm_pkg;
	localparam logic [7:0] BDM_ADDR_PORT0     = 8'h00;
	localparam logic [7:0] BDM_ADDR_PTR0      = 8'h01;
	localparam logic [7:0] BDM_ADDR_PORT1     = 8'h02;
	localparam logic [7:0] BDM_ADDR_PTR1      = 8'h03;
	localparam logic [7:0] BDM_ADDR_BANKSEL   = 8'h04;
	localparam logic [7:0] BDM_ADDR_NVCTRL    = 8'h40;
	localparam logic [7:0] BDM_GP_BASE        = 8'h80;
	localparam int         BDM_GP_DEPTH       = 128;
	localparam int         BDM_BANKSEL_BIT    = 0;
	localparam logic [7:0] BDM_BANKSEL_RST    = 8'h00;
	localparam logic [7:0] BDM_PTR_RST        = 8'h00;
	localparam logic [7:0] BDM_ZERO           = 8'h00;
	localparam logic [3:0] BDM_NVCTRL_MASK    = 4'hf;
	typedef enum {
		BDM_SRC_NONE,
		BDM_SRC_DIRECT,
		BDM_SRC_PORT0,
		BDM_SRC_PORT1
	} bdm_src_e;
endpackage

//--- hdl/bdm_ram_if.sv
// interface between the address decoder and the general purpose ram
`timescale 1ns/1ps
interface bdm_ram_if;
	logic       we;
	logic [6:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport ctrl
	(
		output we,
		output addr,
		output wdata,
		input  rdata
	);
	modport ram
	(
		input  we,
		input  addr,
		input  wdata,
		output rdata
	);
endinterface

//--- hdl/bdm_top.sv
// banked data memory with direct and indirect addressing
`timescale 1ns/1ps
module bdm_top
	import bdm_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       nrst_in,
	input  wire logic       wdt_sleep_rst_in,
	input  wire logic [7:0] addr_in,
	input  wire logic       rd_in,
	input  wire logic       wr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       bit_op_in,
	input  wire logic [2:0] bit_sel_in,
	input  wire logic       bit_val_in,
	output logic      [7:0] rdata_out,
	input  wire logic [7:0] periph_rdata_in,
	input  wire logic       periph_hit_in,
	input  wire logic       periph_ro_in,
	output logic            periph_we_out,
	output logic      [7:0] periph_addr_out,
	output logic      [7:0] periph_wdata_out,
	output logic      [3:0] nonvolatile_control_register_out
);
	// -------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------
	function automatic logic is_port(input logic [7:0] a);
		return (a == BDM_ADDR_PORT0) || (a == BDM_ADDR_PORT1);
	endfunction

	function automatic logic is_gp(input logic [7:0] a);
		return a >= BDM_GP_BASE;
	endfunction

	function automatic logic [7:0] bit_merge(input logic [7:0] old, input logic [2:0] sel,
		input logic val);
		logic [7:0] r;
		r = old;
		r[sel] = val;
		return r;
	endfunction

	// -------------------------------------------------------------
	// state
	// -------------------------------------------------------------
	logic [7:0] pointer_zero_q;
	logic [7:0] pointer_one_q;
	logic       bank_select_bit_q;
	logic [3:0] nvctrl_q;
	logic       sleep_rst_q;

	bdm_ram_if ram_bus ();

	bdm_gp_ram u_ram
	(
		.clk_in  (clk_in),
		.port_in (ram_bus.ram)
	);

	// -------------------------------------------------------------
	// address resolution
	// -------------------------------------------------------------
	bdm_src_e   src;
	logic [7:0] eff_addr;
	logic       eff_bank1;
	logic       to_port;
	logic       hit_gp;
	logic       hit_ptr0;
	logic       hit_ptr1;
	logic       hit_bank;
	logic       hit_nv;
	logic       hit_periph;
	logic [7:0] cur_rdata;
	logic [7:0] wr_value;
	logic       wr_go;

	assign src = (addr_in == BDM_ADDR_PORT0) ? BDM_SRC_PORT0 :
		(addr_in == BDM_ADDR_PORT1) ? BDM_SRC_PORT1 : BDM_SRC_DIRECT;

	always_comb
	begin
		case (src)
			BDM_SRC_PORT0: eff_addr = pointer_zero_q;
			BDM_SRC_PORT1: eff_addr = pointer_one_q;
			BDM_SRC_DIRECT: eff_addr = addr_in;
			default: eff_addr = addr_in;
		endcase
	end

	// only the second port honours the bank select bit
	assign eff_bank1 = (src == BDM_SRC_PORT1) && bank_select_bit_q;
	assign to_port   = (src != BDM_SRC_DIRECT) && is_port(eff_addr);

	assign hit_gp     = !eff_bank1 && !to_port && is_gp(eff_addr);
	assign hit_ptr0   = !eff_bank1 && (eff_addr == BDM_ADDR_PTR0);
	assign hit_ptr1   = !eff_bank1 && (eff_addr == BDM_ADDR_PTR1);
	assign hit_bank   = !eff_bank1 && (eff_addr == BDM_ADDR_BANKSEL);
	assign hit_nv     = eff_bank1 && (eff_addr == BDM_ADDR_NVCTRL);
	assign hit_periph = !eff_bank1 && !to_port && !is_gp(eff_addr) && periph_hit_in
		&& !hit_ptr0 && !hit_ptr1 && !hit_bank;

	// -------------------------------------------------------------
	// read mux
	// -------------------------------------------------------------
	always_comb
	begin
		if (to_port)
			cur_rdata = BDM_ZERO;
		else if (hit_gp)
			cur_rdata = ram_bus.rdata;
		else if (hit_ptr0)
			cur_rdata = pointer_zero_q;
		else if (hit_ptr1)
			cur_rdata = pointer_one_q;
		else if (hit_bank)
			cur_rdata = {7'h00, bank_select_bit_q};
		else if (hit_nv)
			cur_rdata = {4'h0, nvctrl_q};
		else if (hit_periph)
			cur_rdata = periph_rdata_in;
		else
			cur_rdata = BDM_ZERO;
	end

	assign rdata_out = rd_in ? cur_rdata : BDM_ZERO;

	// -------------------------------------------------------------
	// write path: bit operations are read-modify-write of one byte
	// -------------------------------------------------------------
	assign wr_value = bit_op_in ? bit_merge(cur_rdata, bit_sel_in, bit_val_in)
		: wdata_in;
	assign wr_go    = wr_in && !to_port;

	assign ram_bus.we    = wr_go && hit_gp;
	assign ram_bus.addr  = eff_addr[6:0];
	assign ram_bus.wdata = wr_value;

	// read-only peripheral registers flag themselves and are never written
	assign periph_we_out    = wr_go && hit_periph && !periph_ro_in;
	assign periph_addr_out  = eff_addr;
	assign periph_wdata_out = wr_value;
	assign nonvolatile_control_register_out = nvctrl_q;

	// -------------------------------------------------------------
	// registers
	// -------------------------------------------------------------
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			pointer_zero_q <= BDM_PTR_RST;
			pointer_one_q  <= BDM_PTR_RST;
			nvctrl_q       <= 4'h0;
		end
		else
		begin
			if (wr_go && hit_ptr0)
				pointer_zero_q <= wr_value;
			if (wr_go && hit_ptr1)
				pointer_one_q <= wr_value;
			if (wr_go && hit_nv)
				nvctrl_q <= wr_value[3:0] & BDM_NVCTRL_MASK;
		end
	end

	// bank holds and ignores writes while wdt_sleep_rst_in is high (seen one cycle late); nrst_in always clears it
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			sleep_rst_q <= 1'b0;
		else
			sleep_rst_q <= wdt_sleep_rst_in;
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			bank_select_bit_q <= BDM_BANKSEL_RST[BDM_BANKSEL_BIT];
		else if (sleep_rst_q)
			bank_select_bit_q <= bank_select_bit_q;
		else if (wr_go && hit_bank)
			bank_select_bit_q <= wr_value[BDM_BANKSEL_BIT];
	end
endmodule
